// ---- pkg/i2c_ctrl_pkg.sv ----
package i2c_ctrl_pkg;

    // Master line sequencer states
    typedef enum logic [3:0] {
        M_IDLE = 4'h0,
        M_START = 4'h1,
        M_LOW = 4'h2,
        M_HIGH = 4'h3,
        M_STOP1 = 4'h4,
        M_STOP2 = 4'h5,
        M_STOP3 = 4'h6,
        M_RS1 = 4'h7,
        M_RS2 = 4'h8
    } mstate_type;

endpackage : i2c_ctrl_pkg

// ---- pkg/i2c_ctrl_regs.svh ----
`ifndef I2C_CTRL_REGS_SVH
`define I2C_CTRL_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_OWN 8'h00
`define OFS_BAUD 8'h04
`define OFS_CTL 8'h08
`define OFS_STAT 8'h0c
`define OFS_DATA 8'h10

// ----------------------------------------
// Control bits
// ----------------------------------------
`define CTL_EN 7
`define CTL_IE 6
`define CTL_MS 5
`define CTL_TX 4
`define CTL_AK 3
`define CTL_RS 2
`define CTL_MASK 8'hf8

// ----------------------------------------
// Status bits
// ----------------------------------------
`define ST_TCF 7
`define ST_ADDRESSED_AS_SLAVE_FLAG 6
`define ST_BUSY 5
`define ST_ARBITRATION_LOST_FLAG 4
`define ST_SRW 2
`define ST_IIF 1
`define ST_RECEIVED_ACK_BIT 0

// ----------------------------------------
// Reset values and counts
// ----------------------------------------
`define REG_RESET 8'h00
`define BIT_LAST 4'h7
`define BIT_ACK 4'h8
`define BIT_PRE 4'hf
`define DIV_BASE 11'h014
`define DIV_STEP 2
`define PRESCALE_FACTOR_LSB 6
`define IDX_W 6

`endif

// ---- rtl/i2c_ctrl.sv ----
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"

module i2c_ctrl (
    input wire logic pclk,            // bus clock, 100 MHz
    input wire logic presetn,         // async reset, active low
    input wire logic psel,            // APB select
    input wire logic penable,         // APB enable
    input wire logic pwrite,          // APB direction
    input wire logic [7:0] paddr,     // APB byte address
    input wire logic [31:0] pwdata,   // APB write data
    output logic [31:0] prdata,       // APB read data
    output logic pready,              // APB ready
    output logic pslverr,             // APB error on unmapped
    input wire logic scl_in,          // clock line level
    output logic scl_out,             // clock line drive value
    output logic scl_oe,              // high while pulling clock low
    input wire logic sda_in,          // data line level
    output logic sda_out,             // data line drive value
    output logic sda_oe,              // high while pulling data low
    output logic irq                  // interrupt request
);
    import i2c_ctrl_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic scl_m_r, scl_s_r, scl_q_r, sda_m_r, sda_s_r, sda_q_r;
    logic [7:0] own_r, baud_r, ctl_r, rx_data_r, sh_r;
    logic tcf_r, addressed_as_slave_flag_r, busy_r, arbitration_lost_flag_r, srw_r, iif_r, received_ack_bit_r;
    logic [3:0] cnt_r;
    logic rx_bit_r, addr_ph_r, addressed_r, hold_r, rs_req_r;
    mstate_type mstate_r, mstate_nxt;
    logic irq_r, scl_oe_r, sda_oe_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic acc, wr, rd, hit_own, hit_baud, hit_ctl, hit_stat, hit_data;
    logic wr_ctl, wr_stat, wr_data, rd_data, data_acc;
    logic [7:0] wb, rdv;
    assign acc = psel && penable && pready_r;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign hit_own = paddr == `OFS_OWN;
    assign hit_baud = paddr == `OFS_BAUD;
    assign hit_ctl = paddr == `OFS_CTL;
    assign hit_stat = paddr == `OFS_STAT;
    assign hit_data = paddr == `OFS_DATA;
    assign wb = pwdata[7:0];
    assign wr_ctl = wr && hit_ctl;
    assign wr_stat = wr && hit_stat;
    assign wr_data = wr && hit_data;
    assign rd_data = rd && hit_data;
    assign data_acc = wr_data || rd_data;

    // ----------------------------------------
    // Line sampling and bus conditions
    // ----------------------------------------
    logic scl_rise, scl_fall, start_det, stop_det, en;
    assign scl_rise = scl_s_r && !scl_q_r;
    assign scl_fall = !scl_s_r && scl_q_r;
    assign start_det = scl_s_r && scl_q_r && sda_q_r && !sda_s_r;
    assign stop_det = scl_s_r && scl_q_r && !sda_q_r && sda_s_r;
    assign en = ctl_r[`CTL_EN];

    // ----------------------------------------
    // Byte engine events
    // ----------------------------------------
    logic mst_act, xmit, part, last, ack_bit, byte_done, addr_end;
    logic [7:0] rx_byte;
    logic match, tick;
    assign mst_act = mstate_r != M_IDLE;
    // Address byte is always sent by master
    assign xmit = addr_ph_r ? mst_act : ctl_r[`CTL_TX];
    assign part = mst_act || addressed_r;
    assign last = cnt_r == `BIT_LAST;
    assign ack_bit = cnt_r == `BIT_ACK;
    assign byte_done = busy_r && scl_fall && ack_bit && part;
    assign addr_end = busy_r && scl_fall && last && addr_ph_r;
    assign rx_byte = {sh_r[6:0], rx_bit_r};
    assign match = en && addr_end && !mst_act
        && rx_byte[7:1] == own_r[7:1];

    // ----------------------------------------
    // Arbitration loss
    // ----------------------------------------
    logic lose_tx, lose_ack, lose_start, lose_rs, lose_stop, lose;
    assign lose_tx = mst_act && scl_rise && xmit && !ack_bit
        && sh_r[7] && !sda_s_r;
    assign lose_ack = mst_act && scl_rise && !xmit && ack_bit
        && ctl_r[`CTL_AK] && !sda_s_r;
    assign lose_start = !mst_act && busy_r
        && ((wr_ctl && wb[`CTL_MS] && !ctl_r[`CTL_MS])
        || (wr_data && ctl_r[`CTL_MS]));
    assign lose_rs = wr_ctl && wb[`CTL_RS] && !mst_act;
    assign lose_stop = mst_act && stop_det
        && mstate_r != M_STOP2 && mstate_r != M_STOP3;
    assign lose = en && (lose_tx || lose_ack || lose_start
        || lose_rs || lose_stop);

    // ----------------------------------------
    // Register next values
    // ----------------------------------------
    logic [7:0] ctl_nxt, sh_nxt;
    logic iif_nxt, arbitration_lost_flag_nxt, tcf_nxt, addressed_as_slave_flag_nxt, hold_nxt, addressed_nxt;
    logic [3:0] cnt_nxt;
    logic rs_req_nxt;
    // Losing master drops master select and carries on as slave
    assign ctl_nxt = lose ? ((wr_ctl ? wb & `CTL_MASK : ctl_r)
        & ~(8'h01 << `CTL_MS))
        : (wr_ctl ? wb & `CTL_MASK : ctl_r);
    // Set wins over a write-one clear
    assign iif_nxt = (tcf_nxt && !tcf_r) || match || lose
        || (iif_r && !(wr_stat && wb[`ST_IIF]));
    assign arbitration_lost_flag_nxt = lose
        || (arbitration_lost_flag_r && !(wr_stat && wb[`ST_ARBITRATION_LOST_FLAG]));
    assign tcf_nxt = byte_done || (tcf_r && !data_acc);
    assign addressed_as_slave_flag_nxt = match || (addressed_as_slave_flag_r && !wr_ctl && !stop_det);
    assign hold_nxt = en && !stop_det
        && (byte_done || (hold_r && !data_acc));
    assign addressed_nxt = en && (match || (addressed_r && !stop_det
        && !start_det && !(scl_rise && ack_bit && xmit && sda_s_r
        && !mst_act)));
    // Pre-count absorbs the clock fall that follows a start
    assign cnt_nxt = start_det ? `BIT_PRE :
        (busy_r && scl_fall) ? (ack_bit ? 4'h0 : cnt_r + 4'h1) : cnt_r;
    // Data write loads the byte to send; falls shift in sampled bits
    assign sh_nxt = wr_data ? wb :
        (busy_r && scl_fall && !ack_bit && cnt_r != `BIT_PRE) ? rx_byte
        : sh_r;
    assign rs_req_nxt = en && mst_act && mstate_r != M_LOW
        ? (rs_req_r || (wr_ctl && wb[`CTL_RS]))
        : (en && mst_act && !(rs_req_r && tick)
        && (rs_req_r || (wr_ctl && wb[`CTL_RS])));

    // ----------------------------------------
    // Master line sequencer
    // ----------------------------------------
    always_comb begin
        mstate_nxt = mstate_r;
        unique case (mstate_r)
            M_IDLE: begin
                if (wr_data && ctl_r[`CTL_MS] && !busy_r) begin
                    mstate_nxt = M_START;
                end
            end
            M_START: begin
                if (tick) begin
                    mstate_nxt = M_LOW;
                end
            end
            M_LOW: begin
                if (tick && rs_req_r) begin
                    mstate_nxt = M_RS1;
                end else if (tick && hold_r && !ctl_r[`CTL_MS]) begin
                    mstate_nxt = M_STOP1;
                end else if (tick && !hold_r) begin
                    mstate_nxt = M_HIGH;
                end
            end
            M_HIGH: begin
                // Waits while another device stretches the clock
                if (tick && scl_s_r) begin
                    mstate_nxt = M_LOW;
                end
            end
            M_STOP1: begin
                if (tick) begin
                    mstate_nxt = M_STOP2;
                end
            end
            M_STOP2: begin
                if (tick && scl_s_r) begin
                    mstate_nxt = M_STOP3;
                end
            end
            M_STOP3: begin
                if (stop_det) begin
                    mstate_nxt = M_IDLE;
                end
            end
            M_RS1: begin
                if (tick) begin
                    mstate_nxt = M_RS2;
                end
            end
            M_RS2: begin
                if (tick && scl_s_r) begin
                    mstate_nxt = M_START;
                end
            end
            default: begin
                mstate_nxt = M_IDLE;
            end
        endcase
        if (!en || lose) begin
            mstate_nxt = M_IDLE;
        end
    end

    // ----------------------------------------
    // Line drive
    // ----------------------------------------
    logic run_bits, ack_want, eng_low, mst_scl_low, mst_sda_low;
    logic slv_stretch, scl_oe_nxt, sda_oe_nxt;
    assign run_bits = mst_act ? (mstate_r == M_LOW || mstate_r == M_HIGH)
        : addressed_r;
    assign ack_want = addr_ph_r ? addressed_r : !ctl_r[`CTL_AK];
    assign eng_low = busy_r && part && run_bits && !hold_r
        && (ack_bit ? (!xmit && ack_want) : (xmit && !sh_r[7]));
    assign mst_scl_low = mstate_r == M_LOW || mstate_r == M_STOP1
        || mstate_r == M_RS1;
    // Data stays low until the first clock fall is seen, so no false stop
    assign mst_sda_low = mstate_r == M_START || mstate_r == M_STOP1
        || mstate_r == M_STOP2 || (mstate_r == M_LOW && cnt_r == `BIT_PRE);
    // Slave holds the clock low until software touches the data register
    assign slv_stretch = hold_r && addressed_r && !mst_act;
    assign scl_oe_nxt = en && (mst_scl_low || slv_stretch);
    assign sda_oe_nxt = en && !lose
        && (mst_sda_low || eng_low);

    // ----------------------------------------
    // Read mux, sampled in the setup cycle
    // ----------------------------------------
    logic [7:0] stat;
    logic mapped;
    assign stat = {tcf_r, addressed_as_slave_flag_r, busy_r, arbitration_lost_flag_r, 1'b0, srw_r, iif_r,
        received_ack_bit_r};
    assign rdv = hit_own ? own_r : hit_baud ? baud_r :
        hit_ctl ? ctl_r : hit_stat ? stat :
        hit_data ? rx_data_r : `REG_RESET;
    assign mapped = hit_own || hit_baud || hit_ctl || hit_stat || hit_data;

    scl_rate_gen u_rate (
        .pclk (pclk),
        .presetn (presetn),
        .run (en && mst_act),
        .baud (baud_r),
        .tick (tick)
    );

    // ----------------------------------------
    // Flip-flops
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_m_r <= 1'b1;
            scl_s_r <= 1'b1;
            scl_q_r <= 1'b1;
            sda_m_r <= 1'b1;
            sda_s_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_m_r <= scl_in;
            scl_s_r <= scl_m_r;
            scl_q_r <= scl_s_r;
            sda_m_r <= sda_in;
            sda_s_r <= sda_m_r;
            sda_q_r <= sda_s_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            own_r <= `REG_RESET;
            baud_r <= `REG_RESET;
            ctl_r <= `REG_RESET;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            if (wr && hit_own) begin
                own_r <= wb;
            end
            if (wr && hit_baud) begin
                baud_r <= wb;
            end
            ctl_r <= ctl_nxt;
            pready_r <= psel && !penable;
            pslverr_r <= psel && !penable && !mapped;
            if (psel && !penable) begin
                prdata_r <= {24'h00_0000, rdv};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tcf_r <= 1'b0;
            addressed_as_slave_flag_r <= 1'b0;
            busy_r <= 1'b0;
            arbitration_lost_flag_r <= 1'b0;
            srw_r <= 1'b0;
            iif_r <= 1'b0;
            received_ack_bit_r <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            tcf_r <= tcf_nxt;
            addressed_as_slave_flag_r <= addressed_as_slave_flag_nxt;
            busy_r <= start_det || (busy_r && !stop_det);
            arbitration_lost_flag_r <= arbitration_lost_flag_nxt;
            iif_r <= iif_nxt;
            irq_r <= iif_nxt && ctl_nxt[`CTL_IE];
            if (match) begin
                srw_r <= rx_bit_r;
            end
            if (busy_r && scl_rise && ack_bit) begin
                received_ack_bit_r <= sda_s_r;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_r <= `REG_RESET;
            sh_r <= `REG_RESET;
            cnt_r <= 4'h0;
            rx_bit_r <= 1'b1;
            addr_ph_r <= 1'b0;
            addressed_r <= 1'b0;
            hold_r <= 1'b0;
            rs_req_r <= 1'b0;
            mstate_r <= M_IDLE;
            scl_oe_r <= 1'b0;
            sda_oe_r <= 1'b0;
        end else begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            addressed_r <= addressed_nxt;
            rs_req_r <= rs_req_nxt;
            mstate_r <= mstate_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
            addr_ph_r <= start_det || (addr_ph_r && !(busy_r && scl_fall
                && ack_bit));
            if (scl_rise) begin
                rx_bit_r <= sda_s_r;
            end
            if (busy_r && scl_fall && last && part) begin
                rx_data_r <= rx_byte;
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign irq = irq_r;
endmodule : i2c_ctrl

// ---- rtl/scl_rate_gen.sv ----
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"

// Emits one pulse per half serial clock period: factor times divider
module scl_rate_gen (
    input wire logic pclk,         // bus clock
    input wire logic presetn,      // async reset, active low
    input wire logic run,          // count while high
    input wire logic [7:0] baud,   // factor and index
    output logic tick              // one-cycle pulse
);
    logic [10:0] cnt_r;
    logic [10:0] div;
    logic [10:0] half;
    logic tick_r;

    // Divider grows linearly with the index
    assign div = `DIV_BASE
        + 11'({baud[`IDX_W-1:0], 1'b0} * `DIV_STEP);
    // Factor 1, 2 or 4; the unused code acts as 1
    assign half = (baud[7:`PRESCALE_FACTOR_LSB] == 2'h1) ? {div[9:0], 1'b0} :
                  (baud[7:`PRESCALE_FACTOR_LSB] == 2'h2) ? {div[8:0], 2'h0} :
                  div;
    assign tick = tick_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 11'h000;
            tick_r <= 1'b0;
        end else begin
            tick_r <= run && (cnt_r >= half - 11'h001);
            if (!run || cnt_r >= half - 11'h001) begin
                cnt_r <= 11'h000;
            end else begin
                cnt_r <= cnt_r + 11'h001;
            end
        end
    end
endmodule : scl_rate_gen

// ---- verification/i2c_ctrl_asserts.sv ----
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
module i2c_ctrl_asserts (
    input wire logic pclk, // bus clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [7:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic scl_in, // clock line level
    input wire logic scl_out, // clock line drive value
    input wire logic scl_oe, // clock line pulled low
    input wire logic sda_in, // data line level
    input wire logic sda_out, // data line drive value
    input wire logic sda_oe, // data line pulled low
    input wire logic irq // interrupt request
);
    logic ie_seen_r;
    logic en_seen_r;
    wire ctl_wr = psel && penable && pready && pwrite && paddr == `OFS_CTL;
    wire st_rd = pready && !pwrite && paddr == `OFS_STAT;
    wire unmapped = paddr != `OFS_OWN && paddr != `OFS_BAUD
        && paddr != `OFS_CTL && paddr != `OFS_STAT && paddr != `OFS_DATA;

    // Last enable bits written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_seen_r <= 1'b0;
            en_seen_r <= 1'b0;
        end else if (ctl_wr) begin
            ie_seen_r <= pwdata[`CTL_IE];
            en_seen_r <= pwdata[`CTL_EN];
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_timing_a: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    ready_pulse_a: assert property (pready |-> (psel && penable) ##1 !pready)
        else $error("pready outside one access cycle");
    slverr_map_a: assert property (pready |-> pslverr == unmapped)
        else $error("pslverr does not match address decode");
    rdata_clean_a: assert property (pready && !pwrite |->
        prdata[31:8] == 24'h0 && (!pslverr || prdata == 32'h0))
        else $error("read data has stray bits");
    stat_zero_a: assert property (st_rd |-> !prdata[3])
        else $error("reserved status bit not zero");
    irq_flag_a: assert property (st_rd && $past(irq) |-> prdata[`ST_IIF])
        else $error("irq high without combined flag");
    irq_masked_a: assert property (!ie_seen_r ##1 !ie_seen_r |-> !irq)
        else $error("irq high while disabled");
    idle_lines_a: assert property (!en_seen_r [*3] |-> !scl_oe && !sda_oe)
        else $error("disabled module drives a line");
    drive_low_a: assert property (!scl_out && !sda_out)
        else $error("line driven high");

    cover property (st_rd && prdata[`ST_ARBITRATION_LOST_FLAG]);
    cover property (st_rd && prdata[`ST_ADDRESSED_AS_SLAVE_FLAG]);
    cover property ($rose(irq));
endmodule : i2c_ctrl_asserts

bind i2c_ctrl i2c_ctrl_asserts i2c_ctrl_asserts_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
);

// ---- verification/i2c_peer.sv ----
`timescale 1ns/1ps
module i2c_peer #(
    parameter logic [6:0] PEER_ADDR = 7'h3a,
    parameter int HALF_NS = 500,
    parameter int STRETCH_NS = 2000
) (
    input wire logic scl, // clock line level
    input wire logic sda, // data line level
    output logic scl_low, // pull clock line low
    output logic sda_low // pull data line low
);
    logic arm_lose;
    logic [7:0] rx_byte;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        arm_lose = 1'b0;
    end

    // A stop abandons any byte in progress
    always @(posedge sda) if (scl) disable resp;

    initial forever begin : resp
        @(negedge sda iff scl);
        @(negedge scl);
        if (arm_lose) sda_low = 1'b1;
        repeat (8) @(posedge scl) rx_byte = {rx_byte[6:0], sda};
        @(negedge scl);
        if (rx_byte[7:1] == PEER_ADDR) begin
            sda_low = 1'b1;
            @(negedge scl);
            sda_low = 1'b0;
            scl_low = 1'b1;
            #(STRETCH_NS);
            scl_low = 1'b0;
        end
    end

    task automatic m_start();
        sda_low = 1'b1;
        #(HALF_NS);
        scl_low = 1'b1;
    endtask : m_start

    // Eight bits MSB first, then the acknowledge slot
    task automatic m_byte(input logic [7:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_low = (i > 0) ? !b[i - 1] : 1'b0;
            #(HALF_NS);
            scl_low = 1'b0;
            wait (scl === 1'b1);
            if (i == 0) ack = !sda;
            #(HALF_NS);
            scl_low = 1'b1;
        end
    endtask : m_byte

    task automatic m_stop();
        sda_low = 1'b1;
        #(HALF_NS);
        scl_low = 1'b0;
        wait (scl === 1'b1);
        #(HALF_NS);
        sda_low = 1'b0;
    endtask : m_stop
endmodule : i2c_peer

// ---- verification/tb_i2c_interrupt_status_logic.sv ----
`timescale 1ns/1ps
`include "i2c_ctrl_regs.svh"
module tb_i2c_interrupt_status_logic;
    logic pclk, presetn, psel, penable, pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe, irq;
    logic p_scl_low, p_sda_low, ack, err;
    wire scl_w = !(scl_oe || p_scl_low);
    wire sda_w = !(sda_oe || p_sda_low);
    int n_mismatch, n_checks, half, prescale_factor;
    int mdl[int];
    realtime t_hi, hi_ns;

    i2c_ctrl i2c_ctrl_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl_w),
        .scl_out(scl_out), .scl_oe(scl_oe), .sda_in(sda_w),
        .sda_out(sda_out), .sda_oe(sda_oe), .irq(irq)
    );
    i2c_peer i2c_peer_inst (
        .scl(scl_w), .sda(sda_w), .scl_low(p_scl_low), .sda_low(p_sda_low)
    );

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge scl_w) t_hi = $realtime;
    always @(negedge scl_w) hi_ns = $realtime - t_hi;

    task automatic chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) chk("pready", pready, 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_irq();
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 20000) begin
            @(posedge pclk);
            n++;
        end
        chk("irq raised", irq, 1'b1);
    endtask : wait_irq

    task automatic arbitration_lost_flag_seen();
        wait_irq();
        apb(0, `OFS_STAT, 0);
        chk("arbitration_lost_flag", rd[4], 1);
        apb(0, `OFS_CTL, 0);
        chk("master dropped", rd[5], 0);
        apb(1, `OFS_STAT, 8'h10);
        apb(0, `OFS_STAT, 0);
        chk("flag outlives event", rd[4:1], 4'b0001);
        apb(1, `OFS_STAT, 8'h02);
    endtask : arbitration_lost_flag_seen

    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    initial begin
        #900us;
        n_mismatch++;
        give_verdict();
    end

    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        void'($urandom(48359));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        mdl[`OFS_OWN] = ($urandom & 8'h7e) | 8'h80;
        mdl[`OFS_BAUD] = $urandom & 8'hc7;
        mdl[`OFS_CTL] = $urandom & 8'h58;
        mdl[`OFS_STAT] = 0;
        mdl[`OFS_DATA] = 0;
        foreach (mdl[a]) begin
            apb(0, 8'(a), 0);
            chk("reset value", rd, 0);
        end
        apb(1, `OFS_STAT, 8'hff);
        foreach (mdl[a]) if (a != `OFS_DATA) apb(1, 8'(a), mdl[a]);
        foreach (mdl[a]) begin
            apb(0, 8'(a), 0);
            chk("readback", rd, mdl[a]);
        end
        apb(0, 8'h14, 0);
        chk("unmapped data", rd, 0);
        chk("unmapped error", err, 1);
        // Master sends the peer address and gets an acknowledge
        case (mdl[`OFS_BAUD] >> 6)
            1: prescale_factor = 2;
            2: prescale_factor = 4;
            default: prescale_factor = 1;
        endcase
        half = prescale_factor * (20 + 4 * (mdl[`OFS_BAUD] & 7));
        apb(1, `OFS_CTL, 8'hc0);
        apb(1, `OFS_CTL, 8'hd0);
        apb(1, `OFS_CTL, 8'hf0);
        apb(1, `OFS_DATA, 8'h74);
        wait_irq();
        chk("scl high", hi_ns / 10 >= half - 1 && hi_ns / 10 <= half + 4, 1);
        apb(0, `OFS_STAT, 0);
        chk("status after byte", rd, 8'ha2);
        apb(1, `OFS_CTL, 8'hb0);
        @(negedge pclk);
        chk("irq masked", irq, 0);
        apb(1, `OFS_CTL, 8'hf0);
        @(negedge pclk);
        chk("irq unmasked", irq, 1);
        apb(1, `OFS_STAT, 8'h00);
        apb(0, `OFS_STAT, 0);
        chk("flag kept", rd, 8'ha2);
        apb(1, `OFS_STAT, 8'h02);
        apb(0, `OFS_STAT, 0);
        chk("flag cleared", {rd[7:0], irq}, {8'ha0, 1'b0});
        apb(1, `OFS_CTL, 8'hd0);
        for (int i = 0; i < 200 && rd[5] !== 1'b0; i++) apb(0, `OFS_STAT, 0);
        chk("own stop", rd[5:4], 0);
        // Repeated start outside master mode
        apb(1, `OFS_CTL, 8'hc4);
        arbitration_lost_flag_seen();
        // Another party holds data low under our high bit
        i2c_peer_inst.arm_lose = 1'b1;
        apb(1, `OFS_CTL, 8'hf0);
        apb(1, `OFS_DATA, 8'ha0);
        arbitration_lost_flag_seen();
        chk("data released", sda_oe, 0);
        i2c_peer_inst.arm_lose = 1'b0;
        i2c_peer_inst.m_stop();
        // Start attempt while the bus is taken
        i2c_peer_inst.m_start();
        apb(1, `OFS_CTL, 8'hf0);
        arbitration_lost_flag_seen();
        i2c_peer_inst.m_stop();
        // Addressed as slave, read direction
        apb(1, `OFS_CTL, 8'hc0);
        i2c_peer_inst.m_start();
        i2c_peer_inst.m_byte(8'(mdl[`OFS_OWN] | 1), ack);
        chk("slave ack", ack, 1);
        wait_irq();
        apb(0, `OFS_STAT, 0);
        chk("addressed", {rd[6], rd[2], rd[1]}, 3'b111);
        apb(1, `OFS_CTL, 8'hd0);
        apb(0, `OFS_CTL, 0);
        chk("tx select", rd[4], 1);
        apb(1, `OFS_CTL, 8'h00);
        i2c_peer_inst.m_stop();
        give_verdict();
    end
endmodule : tb_i2c_interrupt_status_logic
